/* rtl/cond_eval.sv */
// branch condition evaluation from the status bits
`timescale 1ns/1ps
module cond_eval
   import core_pkg::*;
(
   input wire logic [3:0] cc_i,    // condition field
   input wire logic [7:0] flags_i, // status bits
   output logic taken_o            // condition holds
);
   logic c, z, s, v, sxv;
   assign c = flags_i[FLG_C];
   assign z = flags_i[FLG_Z];
   assign s = flags_i[FLG_S];
   assign v = flags_i[FLG_V];
   assign sxv = s ^ v;
   always_comb begin
      case (cc_i)
         CC_ALWAYS: taken_o = 1'b1;
         CC_NEVER: taken_o = 1'b0;
         CC_CARRY: taken_o = c;
         CC_NO_CARRY: taken_o = !c;
         CC_ZERO: taken_o = z;
         CC_NONZERO: taken_o = !z;
         CC_NEGATIVE: taken_o = s;
         CC_POSITIVE: taken_o = !s;
         CC_OVERFLOW_SET: taken_o = v;
         CC_OVERFLOW_CLEAR: taken_o = !v;
         CC_SIGNED_AT_LEAST: taken_o = !sxv;
         CC_SIGNED_BELOW: taken_o = sxv;
         CC_SIGNED_ABOVE: taken_o = !(z | sxv);
         CC_SIGNED_AT_MOST: taken_o = z | sxv;
         CC_UNSIGNED_ABOVE: taken_o = !c && !z;
         CC_UNSIGNED_AT_MOST: taken_o = c | z;
         default: taken_o = 1'b0;
      endcase
   end
endmodule

/* rtl/core_pkg.sv */
// shared constants for the condition and flag decode block
package core_pkg;
   // control register file addresses
   localparam logic [7:0] ADDR_IRQ_MASK = 8'hFB;
   localparam logic [7:0] ADDR_STATUS = 8'hFC;
   localparam logic [7:0] ADDR_GROUP_BASE = 8'hFD;
   localparam logic [7:0] ADDR_SP_HIGH = 8'hFE;
   localparam logic [7:0] ADDR_SP_LOW = 8'hFF;
   // reset values
   localparam logic [15:0] RESET_VECTOR = 16'h000C;
   localparam logic [7:0] RST_IRQ_MASK = 8'h00;
   localparam logic [7:0] RST_STATUS = 8'h00;
   localparam logic [7:0] RST_GROUP_BASE = 8'h00;
   localparam logic [15:0] RST_SP = 16'h0000;
   // status bit positions
   localparam int FLG_C = 7;
   localparam int FLG_Z = 6;
   localparam int FLG_S = 5;
   localparam int FLG_V = 4;
   localparam int FLG_D = 3;
   localparam int FLG_H = 2;
   localparam int IRQ_GLOBAL_BIT = 7;
   // condition codes
   localparam logic [3:0] CC_NEVER = 4'h0;
   localparam logic [3:0] CC_SIGNED_BELOW = 4'h1;
   localparam logic [3:0] CC_SIGNED_AT_MOST = 4'h2;
   localparam logic [3:0] CC_UNSIGNED_AT_MOST = 4'h3;
   localparam logic [3:0] CC_OVERFLOW_SET = 4'h4;
   localparam logic [3:0] CC_NEGATIVE = 4'h5;
   localparam logic [3:0] CC_ZERO = 4'h6;
   localparam logic [3:0] CC_CARRY = 4'h7;
   localparam logic [3:0] CC_ALWAYS = 4'h8;
   localparam logic [3:0] CC_SIGNED_AT_LEAST = 4'h9;
   localparam logic [3:0] CC_SIGNED_ABOVE = 4'hA;
   localparam logic [3:0] CC_UNSIGNED_ABOVE = 4'hB;
   localparam logic [3:0] CC_OVERFLOW_CLEAR = 4'hC;
   localparam logic [3:0] CC_POSITIVE = 4'hD;
   localparam logic [3:0] CC_NONZERO = 4'hE;
   localparam logic [3:0] CC_NO_CARRY = 4'hF;
   // opcodes and opcode nibbles
   localparam logic [7:0] OPC_JP_INDIRECT = 8'h30;
   localparam logic [7:0] OPC_LOAD_GROUP_BASE = 8'h31;
   localparam logic [7:0] OPC_IRQ_ON = 8'h9F;
   localparam logic [7:0] OPC_IRQ_OFF = 8'h8F;
   localparam logic [7:0] OPC_PUSH = 8'h70;
   localparam logic [7:0] OPC_POP = 8'h50;
   localparam logic [7:0] OPC_CALL = 8'hD6;
   localparam logic [3:0] NIB_REL_BRANCH = 4'hB;
   localparam logic [3:0] NIB_ABS_BRANCH = 4'hD;
   localparam logic [3:0] ALU_ADD = 4'h0;
   localparam logic [3:0] ALU_ADC = 4'h1;
   localparam logic [3:0] ALU_SUB = 4'h2;
   localparam logic [3:0] ALU_SBC = 4'h3;
   localparam logic [3:0] ALU_TEST_COMP = 4'h6;
   localparam logic [3:0] ALU_TEST = 4'h7;
   // operand-mode pairs in the low nibble
   localparam logic [3:0] MODE_R_R = 4'h2;
   localparam logic [3:0] MODE_R_IR = 4'h3;
   localparam logic [3:0] MODE_RG_RG = 4'h4;
   localparam logic [3:0] MODE_RG_IRG = 4'h5;
   localparam logic [3:0] MODE_RG_IM = 4'h6;
   localparam logic [3:0] MODE_IRG_IM = 4'h7;
   localparam logic [3:0] WORK_GROUP_PREFIX = 4'hE;
endpackage

/* rtl/cpu_condition_flag_decode.sv */
// instruction decode, flag update, branches and control registers of the core
// Summary of operation
// - decode condition field: always, never, C, Z, S, V
// - signed tests from sign xor overflow, zero
// - unsigned tests from carry and zero
// - six status bits at 252, software readable/writable
// - stack at 254-255, push predec, pop postinc, call minus two
// - opcode 31 loads group base, flags kept
// - 9F sets mask bit 7, 8F clears it
// - add/adc update flags, clear D; subtract sets D
// - test opcodes set Z,S, clear V, no store
// - upper nibble operation, lower nibble mode pair
// - relative branch adds signed displacement when taken
// - absolute branch loads 16-bit target; 30 indirect
`timescale 1ns/1ps
module cpu_condition_flag_decode
   import core_pkg::*;
(
   input wire logic clk_i,                 // 40 MHz core clock
   input wire logic rst_n_i,               // async reset, active low
   output logic [15:0] pm_addr_o,          // program memory address
   input wire logic [7:0] pm_data_i,       // byte at pm_addr_o, same cycle
   output logic exec_o,                    // execute cycle strobe
   output logic [7:0] op_dst_o,            // destination register address
   output logic [7:0] op_src_o,            // source register address
   output logic [3:0] op_mode_o,           // operand-mode pair nibble
   input wire logic [7:0] dst_val_i,       // destination operand value
   input wire logic [7:0] src_val_i,       // source operand value
   input wire logic [15:0] pair_val_i,     // register pair at op_dst_o
   output logic [7:0] result_o,            // result data
   output logic [7:0] result_addr_o,       // result destination address
   output logic result_we_o,               // result write pulse
   output logic [7:0] stack_raddr_o,       // stack read address
   input wire logic [7:0] stack_rdata_i,   // stack byte at stack_raddr_o
   output logic [7:0] stack_waddr_o,       // stack write address
   output logic [15:0] stack_wdata_o,      // stack write data
   output logic stack_wide_o,              // write is a 16-bit pair
   output logic stack_we_o,                // stack write pulse
   input wire logic [7:0] creg_addr_i,     // control register address
   input wire logic [7:0] creg_wdata_i,    // control register write data
   input wire logic creg_we_i,             // control register write strobe
   output logic [7:0] creg_rdata_o,        // control register read data
   output logic [7:0] irq_mask_o           // interrupt mask contents
);
   typedef enum logic [3:0] {
      ST_FETCH = 4'b0001,
      ST_BYTE2 = 4'b0010,
      ST_BYTE3 = 4'b0100,
      ST_EXEC = 4'b1000
   } state_t;

   state_t state_reg;
   logic [15:0] pc_reg, sp_reg;
   logic [7:0] opc_reg, b2_reg, b3_reg;
   logic [7:0] flags_reg, rp_reg, imr_reg;
   logic [1:0] len;
   logic [3:0] hi, lo;
   logic is_alu, is_rel, is_abs, is_exec, cc_taken;
   logic [15:0] rel_target;
   logic [7:0] src_eff, alu_res;
   logic [8:0] wide;
   logic [4:0] half;
   logic add_op, cin;
   logic [7:0] flags_next;

   assign hi = opc_reg[7:4];
   assign lo = opc_reg[3:0];
   assign is_exec = (state_reg == ST_EXEC);
   assign is_alu = (hi == ALU_ADD || hi == ALU_ADC || hi == ALU_SUB || hi == ALU_SBC ||
                    hi == ALU_TEST_COMP || hi == ALU_TEST) && lo >= MODE_R_R && lo <= MODE_IRG_IM;
   assign is_rel = (lo == NIB_REL_BRANCH);
   assign is_abs = (lo == NIB_ABS_BRANCH);
   assign rel_target = pc_reg + {{8{b2_reg[7]}}, b2_reg};

   // instruction length from the opcode byte on the bus
   function automatic logic [1:0] op_len(input logic [7:0] op);
      logic [1:0] n;
      n = 2'd1;
      if (op[3:0] == NIB_REL_BRANCH || op == OPC_JP_INDIRECT || op == OPC_LOAD_GROUP_BASE ||
          op == OPC_PUSH || op == OPC_POP) begin
         n = 2'd2;
      end else if (op[3:0] == NIB_ABS_BRANCH || op == OPC_CALL) begin
         n = 2'd3;
      end else if ((op[7:4] <= ALU_SBC || op[7:4] == ALU_TEST_COMP || op[7:4] == ALU_TEST) &&
                   op[3:0] >= MODE_R_R && op[3:0] <= MODE_IRG_IM) begin
         n = (op[3:0] <= MODE_R_IR) ? 2'd2 : 2'd3;
      end
      return n;
   endfunction

   cond_eval u_cond (
      .cc_i(hi),
      .flags_i(flags_reg),
      .taken_o(cc_taken)
   );

   // operand addresses per mode pair
   always_comb begin
      op_dst_o = b2_reg;
      op_src_o = b3_reg;
      case (lo)
         MODE_R_R, MODE_R_IR: begin
            op_dst_o = {WORK_GROUP_PREFIX, b2_reg[7:4]};
            op_src_o = {WORK_GROUP_PREFIX, b2_reg[3:0]};
         end
         MODE_RG_RG, MODE_RG_IRG: begin
            op_dst_o = b3_reg;
            op_src_o = b2_reg;
         end
         default: begin
            op_dst_o = b2_reg;
            op_src_o = b3_reg;
         end
      endcase
      if (opc_reg == OPC_PUSH) op_src_o = b2_reg;
   end
   assign op_mode_o = lo;
   assign exec_o = is_exec;
   assign pm_addr_o = pc_reg;
   assign stack_raddr_o = sp_reg[7:0];
   assign irq_mask_o = imr_reg;

   // arithmetic and test datapath
   always_comb begin
      src_eff = (lo == MODE_RG_IM || lo == MODE_IRG_IM) ? b3_reg : src_val_i;
      add_op = (hi == ALU_ADD || hi == ALU_ADC);
      cin = (hi == ALU_ADC || hi == ALU_SBC) ? flags_reg[FLG_C] : 1'b0;
      if (add_op) begin
         wide = {1'b0, dst_val_i} + {1'b0, src_eff} + {8'h00, cin};
         half = {1'b0, dst_val_i[3:0]} + {1'b0, src_eff[3:0]} + {4'h0, cin};
      end else begin
         wide = {1'b0, dst_val_i} - {1'b0, src_eff} - {8'h00, cin};
         half = {1'b0, dst_val_i[3:0]} - {1'b0, src_eff[3:0]} - {4'h0, cin};
      end
      alu_res = wide[7:0];
      flags_next = flags_reg;
      if (hi == ALU_TEST_COMP || hi == ALU_TEST) begin
         alu_res = (hi == ALU_TEST_COMP) ? (~dst_val_i & src_eff) : (dst_val_i & src_eff);
         flags_next[FLG_Z] = (alu_res == 8'h00);
         flags_next[FLG_S] = alu_res[7];
         flags_next[FLG_V] = 1'b0;
      end else begin
         flags_next[FLG_C] = wide[8];
         flags_next[FLG_Z] = (alu_res == 8'h00);
         flags_next[FLG_S] = alu_res[7];
         flags_next[FLG_H] = half[4];
         flags_next[FLG_D] = !add_op;
         if (add_op) begin
            flags_next[FLG_V] = (dst_val_i[7] == src_eff[7]) && (alu_res[7] != dst_val_i[7]);
         end else begin
            flags_next[FLG_V] = (dst_val_i[7] != src_eff[7]) && (alu_res[7] != dst_val_i[7]);
         end
      end
   end

   // fetch sequencer
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= ST_FETCH;
         opc_reg <= 8'h00;
         b2_reg <= 8'h00;
         b3_reg <= 8'h00;
         len <= 2'd1;
      end else begin
         case (state_reg)
            ST_FETCH: begin
               opc_reg <= pm_data_i;
               len <= op_len(pm_data_i);
               state_reg <= (op_len(pm_data_i) == 2'd1) ? ST_EXEC : ST_BYTE2;
            end
            ST_BYTE2: begin
               b2_reg <= pm_data_i;
               state_reg <= (len == 2'd3) ? ST_BYTE3 : ST_EXEC;
            end
            ST_BYTE3: begin
               b3_reg <= pm_data_i;
               state_reg <= ST_EXEC;
            end
            ST_EXEC: state_reg <= ST_FETCH;
            default: state_reg <= ST_FETCH;
         endcase
      end
   end

   // program counter
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pc_reg <= RESET_VECTOR;
      end else if (!is_exec) begin
         pc_reg <= pc_reg + 16'h0001;
      end else if (is_rel && cc_taken) begin
         pc_reg <= rel_target;
      end else if (is_abs && cc_taken) begin
         pc_reg <= {b2_reg, b3_reg};
      end else if (opc_reg == OPC_JP_INDIRECT) begin
         pc_reg <= pair_val_i;
      end else if (opc_reg == OPC_CALL) begin
         pc_reg <= {b2_reg, b3_reg};
      end
   end

   // control registers: instruction updates win over a software write in the same cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flags_reg <= RST_STATUS;
         rp_reg <= RST_GROUP_BASE;
         imr_reg <= RST_IRQ_MASK;
         sp_reg <= RST_SP;
      end else if (is_exec && (is_alu || opc_reg == OPC_LOAD_GROUP_BASE || opc_reg == OPC_IRQ_ON ||
                               opc_reg == OPC_IRQ_OFF || opc_reg == OPC_PUSH || opc_reg == OPC_POP ||
                               opc_reg == OPC_CALL)) begin
         if (is_alu) flags_reg <= flags_next;
         if (opc_reg == OPC_LOAD_GROUP_BASE) rp_reg <= b2_reg;
         if (opc_reg == OPC_IRQ_ON) imr_reg[IRQ_GLOBAL_BIT] <= 1'b1;
         if (opc_reg == OPC_IRQ_OFF) imr_reg[IRQ_GLOBAL_BIT] <= 1'b0;
         if (opc_reg == OPC_PUSH) sp_reg <= sp_reg - 16'h0001;
         if (opc_reg == OPC_POP) sp_reg <= sp_reg + 16'h0001;
         if (opc_reg == OPC_CALL) sp_reg <= sp_reg - 16'h0002;
      end else if (creg_we_i) begin
         case (creg_addr_i)
            ADDR_STATUS: flags_reg <= creg_wdata_i;
            ADDR_GROUP_BASE: rp_reg <= creg_wdata_i;
            ADDR_IRQ_MASK: imr_reg <= creg_wdata_i;
            ADDR_SP_HIGH: sp_reg[15:8] <= creg_wdata_i;
            ADDR_SP_LOW: sp_reg[7:0] <= creg_wdata_i;
            default: ;
         endcase
      end
   end

   // registered read port
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         creg_rdata_o <= 8'h00;
      end else begin
         case (creg_addr_i)
            ADDR_STATUS: creg_rdata_o <= flags_reg;
            ADDR_GROUP_BASE: creg_rdata_o <= rp_reg;
            ADDR_IRQ_MASK: creg_rdata_o <= imr_reg;
            ADDR_SP_HIGH: creg_rdata_o <= sp_reg[15:8];
            ADDR_SP_LOW: creg_rdata_o <= sp_reg[7:0];
            default: creg_rdata_o <= 8'h00;
         endcase
      end
   end

   // result and stack write ports
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         result_o <= 8'h00;
         result_addr_o <= 8'h00;
         result_we_o <= 1'b0;
         stack_waddr_o <= 8'h00;
         stack_wdata_o <= 16'h0000;
         stack_wide_o <= 1'b0;
         stack_we_o <= 1'b0;
      end else begin
         result_we_o <= is_exec && ((is_alu && hi != ALU_TEST_COMP && hi != ALU_TEST) ||
                                    opc_reg == OPC_POP);
         stack_we_o <= is_exec && (opc_reg == OPC_PUSH || opc_reg == OPC_CALL);
         // data and addresses hold until the next execute cycle
         if (is_exec) begin
            result_o <= (opc_reg == OPC_POP) ? stack_rdata_i : alu_res;
            result_addr_o <= (opc_reg == OPC_POP) ? b2_reg : op_dst_o;
            stack_wide_o <= (opc_reg == OPC_CALL);
            stack_waddr_o <= (opc_reg == OPC_CALL) ? (sp_reg[7:0] - 8'h02) : (sp_reg[7:0] - 8'h01);
            stack_wdata_o <= (opc_reg == OPC_CALL) ? pc_reg : {8'h00, src_val_i};
         end
      end
   end

   a_cc_signed: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (hi == CC_SIGNED_ABOVE) |-> cc_taken == !(flags_reg[FLG_Z] | (flags_reg[FLG_S] ^ flags_reg[FLG_V])))
      else $error("signed above condition wrong");
   a_cc_unsigned: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (hi == CC_UNSIGNED_AT_MOST) |-> cc_taken == (flags_reg[FLG_C] | flags_reg[FLG_Z]))
      else $error("unsigned at most condition wrong");
   a_cc_fixed: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ((hi == CC_ALWAYS) |-> cc_taken) and ((hi == CC_NEVER) |-> !cc_taken))
      else $error("fixed condition wrong");
   a_rel_branch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (is_exec && is_rel) |=> pm_addr_o == ($past(cc_taken) ? $past(rel_target) : $past(pc_reg)))
      else $error("relative branch target wrong");
   a_abs_branch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (is_exec && is_abs && cc_taken) |=> pm_addr_o == {$past(b2_reg), $past(b3_reg)})
      else $error("absolute branch target wrong");
   a_group_base: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (is_exec && opc_reg == OPC_LOAD_GROUP_BASE) |=> rp_reg == $past(b2_reg) && $stable(flags_reg))
      else $error("group base load wrong");
   a_irq_enable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (is_exec && opc_reg == OPC_IRQ_ON) |=> irq_mask_o[IRQ_GLOBAL_BIT] && $stable(flags_reg))
      else $error("global enable not set");
   a_irq_disable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (is_exec && opc_reg == OPC_IRQ_OFF) |=> !irq_mask_o[IRQ_GLOBAL_BIT] && $stable(flags_reg))
      else $error("global enable not cleared");
   a_add_dflag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (is_exec && is_alu && hi <= ALU_SBC) |=> flags_reg[FLG_D] == ($past(hi) >= ALU_SUB) && result_we_o)
      else $error("decimal-adjust bit wrong after arithmetic");
   a_test_nostore: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (is_exec && is_alu && hi >= ALU_TEST_COMP) |=> !result_we_o && !flags_reg[FLG_V])
      else $error("test instruction stored or kept overflow");
   a_stack_call: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (is_exec && opc_reg == OPC_CALL) |=> sp_reg == $past(sp_reg) - 16'h0002 && stack_we_o && stack_wide_o)
      else $error("call stack adjust wrong");
   a_status_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (creg_we_i && creg_addr_i == ADDR_STATUS && !is_exec) |=> flags_reg == $past(creg_wdata_i))
      else $error("status write lost");
   c_rel_taken: cover property (@(posedge clk_i) disable iff (!rst_n_i) is_exec && is_rel && cc_taken);
   c_abs_branch: cover property (@(posedge clk_i) disable iff (!rst_n_i) is_exec && is_abs && cc_taken);
   c_alu_write: cover property (@(posedge clk_i) disable iff (!rst_n_i) result_we_o);
   c_call: cover property (@(posedge clk_i) disable iff (!rst_n_i) stack_we_o && stack_wide_o);
endmodule

/* tb/prog_mem_model.sv */
// program memory and register file model beside the core
`timescale 1ns/1ps
module prog_mem_model (
   input wire logic clk_i,                // core clock
   input wire logic [15:0] pm_addr_i,     // fetch address
   output logic [7:0] pm_data_o,          // byte at fetch address
   input wire logic [7:0] op_dst_i,       // destination address
   input wire logic [7:0] op_src_i,       // source address
   output logic [7:0] dst_val_o,          // destination value
   output logic [7:0] src_val_o,          // source value
   output logic [15:0] pair_val_o,        // pair at destination
   input wire logic [7:0] stack_raddr_i,  // stack read address
   output logic [7:0] stack_rdata_o,      // stack byte
   input wire logic [7:0] result_i,       // result data
   input wire logic [7:0] result_addr_i,  // result address
   input wire logic result_we_i,          // result write
   input wire logic [7:0] stack_waddr_i,  // stack write address
   input wire logic [15:0] stack_wdata_i, // stack write data
   input wire logic stack_wide_i,         // pair write
   input wire logic stack_we_i            // stack write
);
   logic [7:0] mem [0:65535];
   logic [7:0] rf [0:255];
   initial begin
      for (int k = 0; k < 65536; k++) mem[k] = 8'h00;
      for (int k = 0; k < 256; k++) rf[k] = 8'h00;
   end
   // the core cannot stall, so every read answers in the same cycle
   assign pm_data_o = mem[pm_addr_i];
   assign dst_val_o = rf[op_dst_i];
   assign src_val_o = rf[op_src_i];
   assign pair_val_o = {rf[op_dst_i], rf[op_dst_i + 8'h01]};
   assign stack_rdata_o = rf[stack_raddr_i];
   always @(posedge clk_i) begin
      if (result_we_i === 1'b1) rf[result_addr_i] <= result_i;
      if (stack_we_i === 1'b1) begin
         if (stack_wide_i === 1'b1) begin
            rf[stack_waddr_i] <= stack_wdata_i[15:8];
            rf[stack_waddr_i + 8'h01] <= stack_wdata_i[7:0];
         end else begin
            rf[stack_waddr_i] <= stack_wdata_i[7:0];
         end
      end
   end
endmodule

/* tb/tb.sv */
// self-checking bench for the condition and flag decode core
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; $display("Error %s exp %h seen %h", nm, e, g); end end
module tb;
   import core_pkg::*;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic creg_we_i = 1'b0;
   logic [7:0] creg_addr_i = 8'h00;
   logic [7:0] creg_wdata_i = 8'h00;
   logic [15:0] pm_addr_o, pair_val_i, stack_wdata_o, sw_data;
   logic [7:0] pm_data_i, op_dst_o, op_src_o, dst_val_i, src_val_i, result_o, result_addr_o;
   logic [7:0] stack_raddr_o, stack_rdata_i, stack_waddr_o, creg_rdata_o, irq_mask_o, sw_addr;
   logic [3:0] op_mode_o, md_seen;
   logic exec_o, result_we_o, stack_wide_o, stack_we_o, sw_wide;
   int seed = 12439;
   int n_errors = 0;
   int checks = 0;
   int n_res = 0;
   int n_ex;
   always #12.5 clk_i = ~clk_i;
   cpu_condition_flag_decode i_cpu_condition_flag_decode (.clk_i(clk_i), .rst_n_i(rst_n_i), .pm_addr_o(pm_addr_o),
      .pm_data_i(pm_data_i), .exec_o(exec_o), .op_dst_o(op_dst_o), .op_src_o(op_src_o), .op_mode_o(op_mode_o),
      .dst_val_i(dst_val_i), .src_val_i(src_val_i), .pair_val_i(pair_val_i), .result_o(result_o),
      .result_addr_o(result_addr_o), .result_we_o(result_we_o), .stack_raddr_o(stack_raddr_o),
      .stack_rdata_i(stack_rdata_i), .stack_waddr_o(stack_waddr_o), .stack_wdata_o(stack_wdata_o),
      .stack_wide_o(stack_wide_o), .stack_we_o(stack_we_o), .creg_addr_i(creg_addr_i),
      .creg_wdata_i(creg_wdata_i), .creg_we_i(creg_we_i), .creg_rdata_o(creg_rdata_o), .irq_mask_o(irq_mask_o));
   prog_mem_model i_prog_mem_model (.clk_i(clk_i), .pm_addr_i(pm_addr_o), .pm_data_o(pm_data_i),
      .op_dst_i(op_dst_o), .op_src_i(op_src_o), .dst_val_o(dst_val_i), .src_val_o(src_val_i),
      .pair_val_o(pair_val_i), .stack_raddr_i(stack_raddr_o), .stack_rdata_o(stack_rdata_i),
      .result_i(result_o), .result_addr_i(result_addr_o), .result_we_i(result_we_o),
      .stack_waddr_i(stack_waddr_o), .stack_wdata_i(stack_wdata_o), .stack_wide_i(stack_wide_o),
      .stack_we_i(stack_we_o));
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) n_ex <= 0;
      else if (exec_o === 1'b1) n_ex <= n_ex + 1;
   end
   always @(posedge clk_i) begin
      if (result_we_o === 1'b1) n_res <= n_res + 1;
      if (exec_o === 1'b1) md_seen <= op_mode_o;
      if (stack_we_o === 1'b1) begin
         sw_addr <= stack_waddr_o;
         sw_data <= stack_wdata_o;
         sw_wide <= stack_wide_o;
      end
   end
   function automatic logic [7:0] r8();
      return 8'($random(seed));
   endfunction
   function automatic logic cond_f(input logic [3:0] cc, input logic [7:0] f);
      logic t;
      case (cc[2:0])
         3'h0: t = 1'b0;
         3'h1: t = f[FLG_S] ^ f[FLG_V];
         3'h2: t = f[FLG_Z] | (f[FLG_S] ^ f[FLG_V]);
         3'h3: t = f[FLG_C] | f[FLG_Z];
         3'h4: t = f[FLG_V];
         3'h5: t = f[FLG_S];
         3'h6: t = f[FLG_Z];
         default: t = f[FLG_C];
      endcase
      return cc[3] ? ~t : t;
   endfunction
   function automatic logic [15:0] alu_f(input logic [3:0] op, input logic [7:0] a, b, f);
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] r, nf;
      logic ci;
      nf = f;
      ci = op[0] & f[FLG_C];
      if (op[2]) begin
         r = op[0] ? (a & b) : (~a & b);
         nf[FLG_V] = 1'b0;
      end else begin
         s = op[1] ? ({1'b0, a} - b - ci) : ({1'b0, a} + b + ci);
         h = op[1] ? ({1'b0, a[3:0]} - b[3:0] - ci) : ({1'b0, a[3:0]} + b[3:0] + ci);
         r = s[7:0];
         nf[FLG_C] = s[8];
         nf[FLG_H] = h[4];
         nf[FLG_D] = op[1];
         nf[FLG_V] = op[1] ? (a[7] != b[7]) && (r[7] != a[7]) : (a[7] == b[7]) && (r[7] != a[7]);
      end
      nf[FLG_Z] = (r == 8'h00);
      nf[FLG_S] = r[7];
      return {r, nf};
   endfunction
   task automatic wr(input logic [7:0] a, d);
      creg_addr_i = a;
      creg_wdata_i = d;
      creg_we_i = 1'b1;
      @(negedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      creg_addr_i = a;
      @(negedge clk_i);
      d = creg_rdata_o;
   endtask
   // two no-ops let the register writes land before the instruction under test
   task automatic run(input logic [7:0] b0, b1, b2, f, s, m, input int ne, output logic [15:0] pc);
      rst_n_i = 1'b0;
      i_prog_mem_model.mem[16'h000C] = 8'hFF;
      i_prog_mem_model.mem[16'h000D] = 8'hFF;
      i_prog_mem_model.mem[16'h000E] = b0;
      i_prog_mem_model.mem[16'h000F] = b1;
      i_prog_mem_model.mem[16'h0010] = b2;
      repeat (8) @(negedge clk_i);
      rst_n_i = 1'b1;
      wr(ADDR_STATUS, f);
      wr(ADDR_SP_LOW, s);
      wr(ADDR_IRQ_MASK, m);
      creg_we_i = 1'b0;
      for (int k = 0; k < 40 && n_ex < ne; k++) @(negedge clk_i);
      `CHK("exec count", ne, n_ex)
      pc = pm_addr_o;
   endtask
   task automatic stop_test();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #(25 * 20000);
      n_errors++;
      stop_test();
   end
   initial begin
      logic [7:0] f, a, b, r, nf, s, m, v, da, sa, q;
      logic [15:0] pc, t, e;
      logic [3:0] op, md, dn;
      int n0;
      f = r8();
      s = r8();
      m = r8();
      run(8'hFF, 8'h00, 8'h00, f, s, m, 3, pc);
      rd(ADDR_STATUS, q);
      `CHK("status", f, q)
      rd(ADDR_SP_LOW, q);
      `CHK("stack low", s, q)
      rd(ADDR_IRQ_MASK, q);
      `CHK("irq mask", m, q)
      `CHK("irq mask out", m, irq_mask_o)
      rd(8'h80, q);
      `CHK("unmapped", 8'h00, q)
      for (int i = 0; i < 34; i++) begin
         f = r8();
         v = (i == 8) ? 8'h80 : r8();
         t = {r8() | 8'h01, r8()};
         if (i < 16 || i > 31) begin
            run({i[3:0], NIB_REL_BRANCH}, v, 8'h00, f, 8'h70, 8'h00, 3, pc);
            e = cond_f(i[3:0], f) ? 16'h0010 + {{8{v[7]}}, v} : 16'h0010;
         end else begin
            run({i[3:0], NIB_ABS_BRANCH}, t[15:8], t[7:0], f, 8'h70, 8'h00, 3, pc);
            e = cond_f(i[3:0], f) ? t : 16'h0011;
         end
         `CHK("branch pc", e, pc)
      end
      i_prog_mem_model.rf[8'h40] = t[15:8];
      i_prog_mem_model.rf[8'h41] = t[7:0];
      run(8'h30, 8'h40, 8'h00, 8'h00, 8'h70, 8'h00, 3, pc);
      `CHK("indirect pc", t, pc)
      for (int i = 0; i < 48; i++) begin
         op = (i % 6 < 4) ? 4'(i % 6) : 4'(i % 6 + 2);
         md = 4'(2 + 2 * ((i / 6) % 3));
         a = (i < 6) ? 8'hFF : r8();
         b = (i < 6) ? 8'h01 : r8();
         f = r8();
         dn = 4'(r8());
         da = (md == MODE_R_R) ? {WORK_GROUP_PREFIX, dn} : {3'b001, dn, 1'b0};
         sa = (md == MODE_R_R) ? {WORK_GROUP_PREFIX, ~dn} : {3'b010, dn, 1'b1};
         i_prog_mem_model.rf[da] = a;
         i_prog_mem_model.rf[sa] = b;
         {r, nf} = alu_f(op, a, b, f);
         n0 = n_res;
         if (md == MODE_R_R) run({op, md}, {dn, ~dn}, 8'h00, f, 8'h70, 8'h00, 3, pc);
         else if (md == MODE_RG_RG) run({op, md}, sa, da, f, 8'h70, 8'h00, 3, pc);
         else run({op, md}, da, b, f, 8'h70, 8'h00, 3, pc);
         rd(ADDR_STATUS, q);
         `CHK("flags", nf, q)
         `CHK("mode pair", md, md_seen)
         if (op[2]) `CHK("stores", n0, n_res)
         else begin
            `CHK("stores", n0 + 1, n_res)
            `CHK("result", r, i_prog_mem_model.rf[da])
            `CHK("result addr", da, result_addr_o)
         end
      end
      v = r8();
      run(OPC_LOAD_GROUP_BASE, v, OPC_IRQ_ON, f, 8'h70, m, 4, pc);
      rd(ADDR_GROUP_BASE, q);
      `CHK("group base", v, q)
      rd(ADDR_STATUS, q);
      `CHK("flags kept", f, q)
      `CHK("mask on", m | 8'h80, irq_mask_o)
      run(OPC_IRQ_OFF, 8'h00, 8'h00, f, 8'h70, m | 8'h80, 3, pc);
      rd(ADDR_IRQ_MASK, q);
      `CHK("mask off", m & 8'h7F, q)
      s = 8'h20 + (r8() & 8'h3F);
      i_prog_mem_model.rf[8'h90] = v;
      run(OPC_PUSH, 8'h90, 8'h00, f, s, m, 3, pc);
      rd(ADDR_SP_LOW, q);
      `CHK("push sp", s - 8'h01, q)
      `CHK("push data", {1'b0, s - 8'h01, v}, {sw_wide, sw_addr, sw_data[7:0]})
      i_prog_mem_model.rf[s] = ~v;
      run(OPC_POP, 8'h91, 8'h00, f, s, m, 3, pc);
      rd(ADDR_SP_LOW, q);
      `CHK("pop sp", s + 8'h01, q)
      `CHK("pop data", ~v, i_prog_mem_model.rf[8'h91])
      run(OPC_CALL, t[15:8], t[7:0], f, s, m, 3, pc);
      rd(ADDR_SP_LOW, q);
      `CHK("call sp", s - 8'h02, q)
      `CHK("call push", {1'b1, s - 8'h02, 16'h0011, t}, {sw_wide, sw_addr, sw_data, pc})
      stop_test();
   end
endmodule
